// ==== rtl/eeprom_access_controller.v ====
/*
  CPU-side data EEPROM access controller: address, data and control
  registers, timed program sequencing, CPU stall and ready interrupt.
  The byte array and the interval counter are separate submodules.
  Assumes a single-cycle register port on i_clk and a CPU that honours
  o_cpu_stall. Flash self-programming interlock is left to software.
  Assumes the register port and the global interrupt enable come from
  logic on i_clk, so no input is resynchronised here.
  Assumes software loads an address before the first access.
*/
// Function
// - Mode bits choose atomic, erase or write
// - Mode writes ignored while strobe set
// - Reset clears mode unless programming busy
// - Level ready interrupt while strobe clear
// - Master enable self-clears after four cycles
// - Strobe starts only within master enable window
// - Strobe held for programming time, self-clears
// - Write launch stalls CPU two cycles
// - Read fetches byte now, stalls four
// - Busy refuses reads and address changes
// - Programming self-timed from local time base
// - Nine-bit address, upper bits read zero
// - Data byte feeds writes, receives reads
// - Enables reset zero, top bits zero
`timescale 1ns/1ns
`include "eeprom_consts.vh"

module eeprom_access_controller #(
  parameter [`EE_TIMER_W-1:0] ATOMIC_CYCLES = `EE_ATOMIC_CYCLES,
  parameter [`EE_TIMER_W-1:0] SPLIT_CYCLES  = `EE_SPLIT_CYCLES
) (
  input  wire        i_clk,           // Core clock, 20 MHz
  input  wire        i_srst,          // Sync reset, high
  input  wire [1:0]  i_reg_sel,       // Register index
  input  wire        i_reg_wr,        // Register write strobe
  input  wire        i_reg_rd,        // Register read strobe
  input  wire [7:0]  i_reg_wdata,     // Write data
  input  wire        i_global_int_en, // CPU global interrupt enable
  output reg  [7:0]  o_reg_rdata,     // Read data, next cycle
  output reg         o_cpu_stall,     // Hold CPU pipeline
  output reg         o_ready_irq      // Ready interrupt level
);

  // Register select decode for the write strobes; the read mux decodes with its own case
  // Kept as a function so all four write strobes decode the index the same way
  function sel_is;
    input [1:0] sel;
    input [1:0] idx;
    begin
      sel_is = (sel == idx);
    end
  endfunction

  // Interval length for a mode code; the reserved code never launches,
  // so its entry only keeps the decode complete
  function [`EE_TIMER_W-1:0] mode_cycles;
    input [1:0] mode;
    begin
      case (mode)
        `EE_MODE_ATOMIC: mode_cycles = ATOMIC_CYCLES;
        `EE_MODE_ERASE:  mode_cycles = SPLIT_CYCLES;
        `EE_MODE_WRITE:  mode_cycles = SPLIT_CYCLES;
        default:         mode_cycles = SPLIT_CYCLES;
      endcase
    end
  endfunction

  // Software-visible state
  // Each register has a _nxt partner set by the processes below
  reg [8:0]  addr_r;
  reg [8:0]  addr_nxt;
  reg [7:0]  data_r;
  reg [7:0]  data_nxt;
  reg [1:0]  mode_r;
  reg [1:0]  mode_nxt;
  reg        rie_r;
  reg        rie_nxt;
  reg        mwe_r;
  reg        mwe_nxt;
  reg [2:0]  mwe_cnt_r;
  reg [2:0]  mwe_cnt_nxt;
  reg [2:0]  stall_cnt_r;
  reg [2:0]  stall_cnt_nxt;

  // Latched operation, kept steady for the whole interval
  reg [1:0]  op_mode_r;
  reg [8:0]  op_addr_r;
  reg [7:0]  op_data_r;

  // Timer and array hookup
  wire       busy;
  wire       done;
  wire [7:0] array_rd;
  reg        launch;
  reg        read_go;
  reg [`EE_TIMER_W-1:0] op_cycles;

  // Next values of the registered outputs
  reg [7:0]  rdata_nxt;
  reg        stall_nxt;
  reg        irq_nxt;

  // Per-register write strobes and control bit requests
  wire ctl_wr  = i_reg_wr && sel_is(i_reg_sel, `EE_IDX_CONTROL);
  wire alo_wr  = i_reg_wr && sel_is(i_reg_sel, `EE_IDX_ADDR_LOW);
  wire ahi_wr  = i_reg_wr && sel_is(i_reg_sel, `EE_IDX_ADDR_HIGH);
  wire dat_wr  = i_reg_wr && sel_is(i_reg_sel, `EE_IDX_DATA);
  wire req_pe  = ctl_wr && i_reg_wdata[`EE_BIT_WSTROBE];
  wire req_rd  = ctl_wr && i_reg_wdata[`EE_BIT_READ];
  wire req_mwe = ctl_wr && i_reg_wdata[`EE_BIT_MWE];
  wire [1:0] wr_mode = i_reg_wdata[`EE_BIT_MODE_HI:`EE_BIT_MODE_LO];

  // Programming interval counter
  // It keeps running through a reset so a started write always ends
  // self-timed interval
  ee_prog_timer u_timer (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_start  (launch),
    .i_cycles (op_cycles),
    .o_busy   (busy),
    .o_done   (done)
  );

  // Byte array, written when the interval expires
  // The write lands one edge after busy falls, with the done pulse
  ee_byte_array u_array (
    .i_clk     (i_clk),
    .i_op_en   (done),
    .i_op_mode (op_mode_r),
    .i_op_addr (op_addr_r),
    .i_op_data (op_data_r),
    .i_rd_addr (addr_r),
    .o_rd_data (array_rd)
  );

  // Mode bits: frozen while the strobe reads set
  // A write that also sets the strobe still loads the mode it carries
  always @* begin
    mode_nxt = mode_r;
    if (ctl_wr && !busy) begin
      mode_nxt = wr_mode;
    end
  end

  // Launch decision and interval length
  // The newly written mode counts, so mode and strobe may share a write
  always @* begin
    launch    = 1'b0;
    op_cycles = SPLIT_CYCLES;
    if (req_pe && mwe_r && !busy) begin
      if (mode_nxt != `EE_MODE_RSVD) begin
        launch = 1'b1;
      end
    end
    op_cycles = mode_cycles(mode_nxt);
  end

  // Read request: refused during programming and behind a launch
  // A read in the launching write is dropped; the array is about to change
  always @* begin
    read_go = 1'b0;
    if (req_rd && !busy && !launch) begin
      read_go = 1'b1;
    end
  end

  // Master write enable with its four-cycle lifetime
  always @* begin
    mwe_nxt     = mwe_r;
    mwe_cnt_nxt = mwe_cnt_r;
    // Count down the arming window one edge at a time
    if (mwe_r) begin
      if (mwe_cnt_r == 3'h1) begin
        mwe_nxt     = 1'b0;
        mwe_cnt_nxt = 3'h0;
      end else begin
        mwe_cnt_nxt = mwe_cnt_r - 3'h1;
      end
    end
    // A launch consumes the enable so one arming gives one write
    if (launch) begin
      mwe_nxt     = 1'b0;
      mwe_cnt_nxt = 3'h0;
    end else if (req_mwe) begin
      mwe_nxt     = 1'b1;
      mwe_cnt_nxt = `EE_MWE_TIMEOUT;
    end else if (ctl_wr) begin
      // Any control write without the enable bit disarms the window
      mwe_nxt     = 1'b0;
      mwe_cnt_nxt = 3'h0;
    end
  end

  // Address, data and interrupt enable updates
  always @* begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    rie_nxt  = rie_r;
    if (alo_wr && !busy) begin
      addr_nxt = {addr_r[8], i_reg_wdata};
    end
    if (ahi_wr && !busy) begin
      addr_nxt = {i_reg_wdata[0], addr_r[7:0]};
    end
    // Data stays writable while busy: the operand is latched at launch
    if (dat_wr) begin
      data_nxt = i_reg_wdata;
    end
    if (read_go) begin
      data_nxt = array_rd;
    end
    // Interrupt enable follows every control write, busy or not
    if (ctl_wr) begin
      rie_nxt = i_reg_wdata[`EE_BIT_RIE];
    end
  end

  // CPU stall length after a strobe
  always @* begin
    stall_cnt_nxt = stall_cnt_r;
    // Count the stall down to zero
    if (stall_cnt_r != 3'h0) begin
      stall_cnt_nxt = stall_cnt_r - 3'h1;
    end
    // Launch and read_go are exclusive, so only one count is loaded
    // write stall
    if (launch) begin
      stall_cnt_nxt = `EE_STALL_WRITE;
    end
    if (read_go) begin
      stall_cnt_nxt = `EE_STALL_READ;
    end
  end

  // Mode and latched operation survive a reset taken mid-programming
  // The latched operand still feeds the array after such a reset
  always @(posedge i_clk) begin
    if (i_srst) begin
      if (busy) begin
        mode_r <= mode_r;
      end else begin
        mode_r    <= `EE_MODE_RESET;
        op_mode_r <= `EE_MODE_RESET;
        op_addr_r <= `EE_ADDR_RESET;
        op_data_r <= `EE_BYTE_ZERO;
      end
    end else begin
      mode_r <= mode_nxt;
      if (launch) begin
        op_mode_r <= mode_nxt;
        op_addr_r <= addr_r;
        op_data_r <= data_r;
      end
    end
  end

  // Ordinary control state
  // Address and data reset to zero so a missed load reads a known byte
  always @(posedge i_clk) begin
    if (i_srst) begin
      addr_r      <= `EE_ADDR_RESET;
      data_r      <= `EE_BYTE_ZERO;
      rie_r       <= 1'b0;
      mwe_r       <= 1'b0;
      mwe_cnt_r   <= 3'h0;
      stall_cnt_r <= 3'h0;
    end else begin
      addr_r      <= addr_nxt;
      data_r      <= data_nxt;
      rie_r       <= rie_nxt;
      mwe_r       <= mwe_nxt;
      mwe_cnt_r   <= mwe_cnt_nxt;
      stall_cnt_r <= stall_cnt_nxt;
    end
  end

  // Stall and interrupt next values
  always @* begin
    stall_nxt = (stall_cnt_nxt != 3'h0);
    // level ready interrupt
    // A launch drops the level at the edge that sets the strobe,
    // so the CPU never sees a ready request for a busy array
    irq_nxt   = rie_nxt && i_global_int_en && !busy && !launch;
  end

  // Stall and interrupt outputs, registered for clean timing
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_cpu_stall <= 1'b0;
      o_ready_irq <= 1'b0;
    end else begin
      o_cpu_stall <= stall_nxt;
      o_ready_irq <= irq_nxt;
    end
  end

  // Register read mux; the strobe bit tracks the timer directly
  always @* begin
    rdata_nxt = o_reg_rdata;
    if (i_reg_rd) begin
      case (i_reg_sel)
        `EE_IDX_ADDR_LOW:  rdata_nxt = addr_r[7:0];
        `EE_IDX_ADDR_HIGH: rdata_nxt = {7'h00, addr_r[8]};
        `EE_IDX_DATA:      rdata_nxt = data_r;
        `EE_IDX_CONTROL:   rdata_nxt = {2'h0, mode_r, rie_r, mwe_r, busy, 1'b0};
        default:           rdata_nxt = `EE_BYTE_ZERO;
      endcase
    end
  end

  // Read data holds between reads so a slow CPU can take it late
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= `EE_BYTE_ZERO;
    end else begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // Limitation: the interval is counted on i_clk rather than on a
  // separate oscillator, so its length follows the core clock. The
  // oscillator tick count `EE_RC_WRITE_CYCLES stays in the header so a
  // later time base can be checked against it. A different core clock
  // changes every interval in proportion; ATOMIC_CYCLES and
  // SPLIT_CYCLES must then be rescaled with it.

endmodule // eeprom_access_controller

// ==== common/eeprom_consts.vh ====
/*
  Constants for the data EEPROM access controller: register indices,
  control field positions, mode codes, reset values and timing counts.
  Assumes a 20 MHz core clock; included by its bare name.
*/
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// Register indices on the CPU register port
`define EE_IDX_ADDR_LOW      2'h0
`define EE_IDX_ADDR_HIGH     2'h1
`define EE_IDX_DATA          2'h2
`define EE_IDX_CONTROL       2'h3

// Control register field positions
`define EE_BIT_READ          0
`define EE_BIT_WSTROBE       1
`define EE_BIT_MWE           2
`define EE_BIT_RIE           3
`define EE_BIT_MODE_LO       4
`define EE_BIT_MODE_HI       5

// Programming mode codes
`define EE_MODE_ATOMIC       2'h0
`define EE_MODE_ERASE        2'h1
`define EE_MODE_WRITE        2'h2
`define EE_MODE_RSVD         2'h3
`define EE_MODE_RESET        2'h0

// Reset values and erased state
`define EE_BYTE_ZERO         8'h00
`define EE_BYTE_ERASED       8'hFF
`define EE_ADDR_RESET        9'h000

// Timing: clock period, printed times and derived cycle counts
`define EE_CLK_PERIOD_NS     50
`define EE_ATOMIC_TIME_US    3400
`define EE_SPLIT_TIME_US     1800
// Interval counts: 3.4 ms and 1.8 ms of 50 ns cycles, sized to the timer
`define EE_ATOMIC_CYCLES     17'h109A0
`define EE_SPLIT_CYCLES      17'h08CA0
`define EE_RC_WRITE_CYCLES   26368
`define EE_RC_WRITE_TIME_US  3300
`define EE_MWE_TIMEOUT       3'h4
`define EE_STALL_WRITE       3'h2
`define EE_STALL_READ        3'h4
`define EE_TIMER_W           17

`endif

// ==== rtl/ee_prog_timer.v ====
/*
  Self-timed programming interval counter. Counts i_clk cycles from a
  start pulse and flags completion. Assumes i_cycles is at least one.
*/
`timescale 1ns/1ns
`include "eeprom_consts.vh"

module ee_prog_timer (
  input  wire                       i_clk,    // Core clock
  input  wire                       i_srst,   // Sync reset, high
  input  wire                       i_start,  // Start pulse
  input  wire [`EE_TIMER_W-1:0]     i_cycles, // Interval length
  output reg                        o_busy,   // Interval running
  output reg                        o_done    // Interval end pulse
);

  reg [`EE_TIMER_W-1:0] count_r;

  // A reset during programming must not abort the array operation
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      if (o_busy) begin
        count_r <= count_r - 1'b1;
        if (count_r == {`EE_TIMER_W{1'b0}}) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end else begin
        count_r <= {`EE_TIMER_W{1'b0}};
        o_busy  <= 1'b0;
      end
    end else if (i_start) begin
      count_r <= i_cycles - 1'b1;
      o_busy  <= 1'b1;
    end else if (o_busy) begin
      count_r <= count_r - 1'b1;
      if (count_r == {`EE_TIMER_W{1'b0}}) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end

endmodule // ee_prog_timer

// ==== rtl/ee_byte_array.v ====
/*
  512 x 8 data EEPROM array model. Erase sets a byte to all ones, write
  only clears bits, atomic does both. Read is combinational.
*/
`timescale 1ns/1ns
`include "eeprom_consts.vh"

module ee_byte_array (
  input  wire        i_clk,     // Core clock
  input  wire        i_op_en,   // Apply operation pulse
  input  wire [1:0]  i_op_mode, // Operation code
  input  wire [8:0]  i_op_addr, // Operation address
  input  wire [7:0]  i_op_data, // Byte to program
  input  wire [8:0]  i_rd_addr, // Read address
  output wire [7:0]  o_rd_data  // Byte at read address
);

  reg [7:0] mem [0:511];

  // Array update at the end of the programming interval
  always @(posedge i_clk) begin
    if (i_op_en) begin
      case (i_op_mode)
        `EE_MODE_ATOMIC: mem[i_op_addr] <= i_op_data;
        `EE_MODE_ERASE:  mem[i_op_addr] <= `EE_BYTE_ERASED;
        `EE_MODE_WRITE:  mem[i_op_addr] <= mem[i_op_addr] & i_op_data;
        default:         mem[i_op_addr] <= mem[i_op_addr];
      endcase
    end
  end

  assign o_rd_data = mem[i_rd_addr];

endmodule // ee_byte_array

// ==== sim/eeprom_access_controller_assertions.sv ====
/*
  Port checker for the EEPROM access controller.
  Assumes the bench arms and launches writes only while the array is idle.
*/
`timescale 1ns/1ns
`include "eeprom_consts.vh"

module eeprom_access_controller_checker #(
  parameter [`EE_TIMER_W-1:0] ATOMIC_CYCLES = 20,
  parameter [`EE_TIMER_W-1:0] SPLIT_CYCLES  = 10
) (
  input wire       i_clk,           // Core clock
  input wire       i_srst,          // Sync reset
  input wire [1:0] i_reg_sel,       // Register index
  input wire       i_reg_wr,        // Write strobe
  input wire       i_reg_rd,        // Read strobe
  input wire [7:0] i_reg_wdata,     // Write data
  input wire       i_global_int_en, // Global enable
  input wire [7:0] o_reg_rdata,     // Read data
  input wire       o_cpu_stall,     // CPU hold
  input wire       o_ready_irq      // Ready level
);
  // One clock domain, quiet while reset is high
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // Control register decodes
  wire ctl_wr = i_reg_wr && (i_reg_sel == 2'h3);
  wire ctl_rd = i_reg_rd && (i_reg_sel == 2'h3);

  // Arm, then strobe with a usable mode on the next edge
  sequence arm_s;
    ctl_wr && (i_reg_wdata[2:0] == 3'b100);
  endsequence
  sequence launch_s;
    arm_s ##1 (ctl_wr && (i_reg_wdata[1:0] == 2'b10) && (i_reg_wdata[5:4] != 2'b11));
  endsequence

  write_stall_a: assert property (launch_s |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("write stall length wrong");
  stall_shape_a: assert property ($rose(o_cpu_stall) |-> ##1 o_cpu_stall ##1
    (!o_cpu_stall or (o_cpu_stall ##1 o_cpu_stall ##1 !o_cpu_stall)))
    else $error("stall neither two nor four cycles");
  launch_irq_a: assert property (launch_s |-> ##2 !o_ready_irq [*3])
    else $error("ready interrupt high while programming");
  irq_gie_a: assert property (!i_global_int_en |=> !o_ready_irq)
    else $error("ready interrupt without global enable");
  ctl_top_a: assert property (ctl_rd |=> o_reg_rdata[7:6] == 2'b00)
    else $error("control top bits not zero");
  addr_top_a: assert property (i_reg_rd && (i_reg_sel == 2'h1) |=> o_reg_rdata[7:1] == 7'h00)
    else $error("address high spare bits not zero");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  mwe_live_a: assert property (arm_s ##1 (!i_reg_wr) [*3] ##1 (ctl_rd && !i_reg_wr)
    |=> o_reg_rdata[2])
    else $error("master enable gone too early");
  mwe_expire_a: assert property (arm_s ##1 (!i_reg_wr) [*4] ##1 (ctl_rd && !i_reg_wr)
    |=> !o_reg_rdata[2])
    else $error("master enable did not time out");
endmodule // eeprom_access_controller_checker

bind eeprom_access_controller eeprom_access_controller_checker #(
  .ATOMIC_CYCLES(ATOMIC_CYCLES),
  .SPLIT_CYCLES (SPLIT_CYCLES)
) chk_i (
  .i_clk          (i_clk),
  .i_srst         (i_srst),
  .i_reg_sel      (i_reg_sel),
  .i_reg_wr       (i_reg_wr),
  .i_reg_rd       (i_reg_rd),
  .i_reg_wdata    (i_reg_wdata),
  .i_global_int_en(i_global_int_en),
  .o_reg_rdata    (o_reg_rdata),
  .o_cpu_stall    (o_cpu_stall),
  .o_ready_irq    (o_ready_irq)
);

// ==== sim/tb_eeprom_access_controller.sv ====
/*
  Self-checking bench for the EEPROM access controller.
  Assumes short programming counts and a CPU that waits out each stall.
*/
`timescale 1ns/1ns

`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb_eeprom_access_controller;
  localparam integer NA = 20;
  localparam integer NS = 10;
  reg         i_clk, i_srst, i_reg_wr, i_reg_rd, i_global_int_en, rie, gie;
  reg  [1:0]  i_reg_sel, m;
  reg  [7:0]  i_reg_wdata, d;
  wire [7:0]  o_reg_rdata;
  wire        o_cpu_stall, o_ready_irq;
  reg  [15:0] seed, x;
  reg  [8:0]  a;
  reg  [7:0]  mem [0:511];
  integer     miscompares, num_checks, k, r;

  eeprom_access_controller #(.ATOMIC_CYCLES(17'd20), .SPLIT_CYCLES(17'd10)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_global_int_en(i_global_int_en),
    .o_reg_rdata(o_reg_rdata), .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq));

  // 20 MHz core clock
  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  // Repeatable xorshift source
  function automatic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    rnd = seed;
  endfunction

  // Byte left in the array by one operation
  function automatic [7:0] prog_res(input [1:0] pm, input [7:0] old, input [7:0] dat);
    prog_res = (pm == 2'h0) ? dat : (pm == 2'h1) ? 8'hFF : (old & dat);
  endfunction

  // One register cycle, launched 1 ns after an edge
  task acc(input w, input rd, input [1:0] s, input [7:0] v);
    i_reg_wr = w;
    i_reg_rd = rd;
    i_reg_sel = s;
    i_reg_wdata = v;
    @(posedge i_clk);
    #1;
  endtask

  task idle(input integer n);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask

  task rdx(input [1:0] s, input [7:0] e);
    acc(1'b0, 1'b1, s, 8'h00);
    `CHK(o_reg_rdata, e)
  endtask

  // The CPU idles while the stall is up
  task stall_chk(input integer n);
    repeat (n) begin
      `CHK(o_cpu_stall, 1'b1)
      idle(1);
    end
    `CHK(o_cpu_stall, 1'b0)
  endtask

  // Full write, probes while busy, then read back
  task prog(input [1:0] pm, input integer n);
    i_global_int_en = 1'b0;
    acc(1'b1, 1'b0, 2'h0, a[7:0]);
    acc(1'b1, 1'b0, 2'h1, {7'h00, a[8]});
    acc(1'b1, 1'b0, 2'h2, d);
    acc(1'b1, 1'b0, 2'h3, {4'h0, rie, 3'b100});
    acc(1'b1, 1'b0, 2'h3, {2'b00, pm, rie, 3'b010});
    stall_chk(2);
    // Global enable set to the random gie while the array is busy
    i_global_int_en = gie;
    acc(1'b1, 1'b0, 2'h0, ~a[7:0]);
    acc(1'b1, 1'b0, 2'h2, ~d);
    acc(1'b1, 1'b0, 2'h3, {4'h3, rie, 3'b001});
    `CHK(o_cpu_stall, 1'b0)
    rdx(2'h3, {2'b00, pm, rie, 3'b010});
    idle(n - 8);
    rdx(2'h3, {2'b00, pm, rie, 3'b010});
    idle(1);
    rdx(2'h3, {2'b00, pm, rie, 3'b000});
    `CHK(o_ready_irq, rie & i_global_int_en)
    mem[a] = prog_res(pm, mem[a], d);
    acc(1'b1, 1'b0, 2'h3, {2'b00, pm, rie, 3'b001});
    stall_chk(4);
    rdx(2'h2, mem[a]);
    rdx(2'h0, a[7:0]);
    rdx(2'h1, {7'h00, a[8]});
  endtask

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if ((miscompares == 0) && (num_checks > 0))
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    miscompares = miscompares + 1;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    seed = 16'd56460;
    miscompares = 0;
    num_checks = 0;
    i_srst = 1'b1;
    i_global_int_en = 1'b0;
    rie = 1'b0;
    i_reg_sel = 2'h0;
    i_reg_wdata = 8'h00;
    idle(10);
    i_srst = 1'b0;
    rdx(2'h3, 8'h00);
    acc(1'b1, 1'b0, 2'h1, 8'hFF);
    rdx(2'h1, 8'h01);
    $display("test reset values done");
    // Erase, atomic, then write-only on the same byte
    for (r = 0; r < 2; r = r + 1) begin
      x = rnd();
      a = x[8:0];
      for (k = 0; k < 3; k = k + 1) begin
        x = rnd();
        d = x[15:8];
        rie = x[0];
        gie = x[1];
        m = (k == 0) ? 2'h1 : (k == 1) ? 2'h0 : 2'h2;
        prog(m, (m == 2'h0) ? NA : NS);
      end
    end
    $display("test modes done");
    // Reset in mid-programming keeps the mode
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    acc(1'b1, 1'b0, 2'h3, 8'h22);
    stall_chk(2);
    i_srst = 1'b1;
    idle(1);
    i_srst = 1'b0;
    rdx(2'h3, 8'h22);
    idle(NS);
    rdx(2'h3, 8'h20);
    $display("test reset busy done");
    // Master enable window edges
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    idle(3);
    rdx(2'h3, 8'h04);
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    idle(4);
    rdx(2'h3, 8'h00);
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    idle(4);
    acc(1'b1, 1'b0, 2'h3, 8'h02);
    `CHK(o_cpu_stall, 1'b0)
    rdx(2'h3, 8'h00);
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    idle(3);
    acc(1'b1, 1'b0, 2'h3, 8'h22);
    stall_chk(2);
    idle(NS);
    // Reserved mode code starts nothing
    acc(1'b1, 1'b0, 2'h3, 8'h04);
    acc(1'b1, 1'b0, 2'h3, 8'h32);
    `CHK(o_cpu_stall, 1'b0)
    acc(1'b0, 1'b1, 2'h3, 8'h00);
    `CHK(o_reg_rdata[1], 1'b0)
    $display("test enable window done");
    tally_and_finish;
  end
endmodule // tb_eeprom_access_controller
